/* File: shared/bpt_defs.svh */
// Register offsets, field positions and reset values of the breakpoint and tagging block
`ifndef BPT_DEFS_SVH
`define BPT_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BPT_OFS_CTRL0 8'h20
`define BPT_OFS_CTRL1 8'h21
`define BPT_OFS_ADDR_HI 8'h22
`define BPT_OFS_ADDR_LO 8'h23
`define BPT_OFS_DATA_HI 8'h24
`define BPT_OFS_DATA_LO 8'h25

// ----------------------------------------
// Control 0 fields
// ----------------------------------------
`define BPT_C0_MODE_MSB 7
`define BPT_C0_MODE_LSB 6
`define BPT_C0_PROG_ONLY 5
`define BPT_C0_ALE1 3
`define BPT_C0_ALE0 2
`define BPT_C0_WMASK 8'hec

// ----------------------------------------
// Control 1 fields
// ----------------------------------------
`define BPT_C1_DBE 6
`define BPT_C1_MBH 5
`define BPT_C1_MBL 4
`define BPT_C1_RWE1 3
`define BPT_C1_RW1 2
`define BPT_C1_RWE0 1
`define BPT_C1_RW0 0
`define BPT_C1_WMASK 8'h7f

// ----------------------------------------
// Mode codes, reset values, sizes
// ----------------------------------------
`define BPT_MODE_OFF 2'h0
`define BPT_MODE_SWI_DUAL 2'h1
`define BPT_MODE_BDM_FULL 2'h2
`define BPT_MODE_BDM_DUAL 2'h3
`define BPT_REG_RESET 8'h00
`define BPT_QUEUE_DEPTH 3
`define BPT_QPTR_W 2

`endif

/* File: shared/bpt_pkg.sv */
// Types shared by the breakpoint and tagging block
package bpt_pkg;

	// CPU bus cycle as seen by the comparators
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
		logic rnw;
		logic valid;
		logic progFetch;
	} bpt_cpu_bus_t;

	// Tag carried with one fetched program word
	typedef struct packed {
		logic [15:0] word;
		logic tag_high_n;
		logic tag_low_n;
		logic swiKind;
	} bpt_q_entry_t;

	// Break-at-boundary sequencer
	typedef enum logic [0:0] {
		BRK_IDLE,
		BRK_WAIT
	} bpt_brk_state_t;

endpackage : bpt_pkg

/* File: core/bpt_tag_queue.sv */
// Instruction queue that carries byte tags beside fetched program words
`timescale 1ns/1ps
`default_nettype none
`include "bpt_defs.svh"

module bpt_tag_queue (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic push,
	input wire bpt_pkg::bpt_q_entry_t pushEntry,
	input wire logic pop,
	input wire logic headOdd,
	input wire logic flush,
	output logic headTagged,
	output logic headSwi,
	output logic full,
	output logic empty
);
	import bpt_pkg::*;

	bpt_q_entry_t entry_r [`BPT_QUEUE_DEPTH];
	logic [`BPT_QPTR_W-1:0] rdPtr_r;
	logic [`BPT_QPTR_W-1:0] wrPtr_r;
	logic [`BPT_QPTR_W-1:0] count_r;
	logic doPush;
	logic doPop;

	// ----------------------------------------
	// Pointers and occupancy
	// ----------------------------------------
	assign full = (count_r == `BPT_QPTR_W'(`BPT_QUEUE_DEPTH));
	assign empty = (count_r == '0);
	// A push into a full queue is dropped unless a pop comes in the same cycle; the fetch unit never runs that far ahead
	assign doPush = push && (!full || pop);
	assign doPop = pop && !empty;

	// Pointer wrap at the queue depth
	function automatic logic [`BPT_QPTR_W-1:0] bumpPtr(input logic [`BPT_QPTR_W-1:0] p);
		bumpPtr = (p == `BPT_QPTR_W'(`BPT_QUEUE_DEPTH - 1)) ? '0 : p + `BPT_QPTR_W'(1);
	endfunction : bumpPtr

	always_ff @(posedge sys_clk)
	begin
		if (reset || flush)
		begin
			rdPtr_r <= '0;
			wrPtr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			if (doPush)
				wrPtr_r <= bumpPtr(wrPtr_r);
			if (doPop)
				rdPtr_r <= bumpPtr(rdPtr_r);
			if (doPush && !doPop)
				count_r <= count_r + `BPT_QPTR_W'(1);
			else if (doPop && !doPush)
				count_r <= count_r - `BPT_QPTR_W'(1);
		end
	end

	// ----------------------------------------
	// Entry storage, tag rides with its word
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `BPT_QUEUE_DEPTH; gi++)
		begin : gEntry
			always_ff @(posedge sys_clk)
			begin
				if (reset)
					entry_r[gi] <= '0;
				else if (doPush && (wrPtr_r == `BPT_QPTR_W'(gi)))
					entry_r[gi] <= pushEntry;
			end
		end
	endgenerate

	// Head byte picks its own tag; odd start means the low byte
	assign headTagged = !empty && (headOdd ? entry_r[rdPtr_r].tag_low_n : entry_r[rdPtr_r].tag_high_n);
	assign headSwi = entry_r[rdPtr_r].swiKind;

	AST_QUEUE_NO_OVERFLOW : assert property (@(posedge sys_clk) disable iff (reset)
		full && push && !pop && !flush |=> $stable(count_r))
		else $error("tag queue count moved on a dropped push");

endmodule : bpt_tag_queue

`default_nettype wire

/* File: core/bpt_breakpoint.sv */
// Breakpoint comparators and instruction tagging front end
//
// Operation
// - Comparator zero direction qualifier: write or read
// - Comparator one direction qualifier in BDM dual mode only
// - Address high register matches upper address byte
// - Address low register used only when enabled
// - Data high matches data or address byte
// - Data low matches data or address byte
// - Start command turns two pins into tags
// - Tag levels latched at bus clock fall
// - Each low tag pin tags its byte
// - Tagging any mode, stops on debug entry
// - Serial commands ignored while tagging active
// - Tag follows queue; head tag enters debug
// - No matches while debug mode active
// - Break at boundary, or executed-only via tags
// - Data compare off excludes data registers
// - High mask drops upper data byte
`timescale 1ns/1ps
`default_nettype none
`include "bpt_defs.svh"

module bpt_breakpoint (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData_r,
	input wire bpt_pkg::bpt_cpu_bus_t cpuBus,
	input wire logic instrBoundary,
	input wire logic queueAdvance,
	input wire logic headOdd,
	input wire logic bdmActive,
	input wire logic startTaggingCommand,
	input wire logic busEClockPin,
	input wire logic tagLowPin_n,
	input wire logic tagHighPin_n,
	input wire logic cpuLowStrobe_n,
	input wire logic cpuLowStrobeEn,
	input wire logic serialOut,
	input wire logic serialOe,
	output logic lowStrobePinOut_r,
	output logic lowStrobePinOe_r,
	output logic serialPinOut_r,
	output logic serialPinOe_r,
	output logic tagActive_r,
	output logic serialCmdIgnore_r,
	output logic bdmEntry_r,
	output logic swiRequest_r
);
	import bpt_pkg::*;

	logic [7:0] ctrl0_r;
	logic [7:0] ctrl1_r;
	logic [7:0] addrHigh_r;
	logic [7:0] addrLow_r;
	logic [7:0] dataHigh_r;
	logic [7:0] dataLow_r;
	logic [2:0] syncA_r;
	logic [2:0] syncB_r;
	logic eclkPrev_r;
	logic eclkFall;
	logic pendTagHi_r;
	logic pendTagLo_r;
	logic bdmPrev_r;
	bpt_brk_state_t brkState_r;
	bpt_q_entry_t pushEntry;
	logic [1:0] mode;
	logic dualMode;
	logic dirOk0;
	logic dirOk1;
	logic cmp0Hit;
	logic cmp1Hit;
	logic dataOk;
	logic anyHit;
	logic tagPath;
	logic headTagged;
	logic headSwi;

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	// All six registers reset to zero and are writable at any time
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			ctrl0_r <= `BPT_REG_RESET;
			ctrl1_r <= `BPT_REG_RESET;
			addrHigh_r <= `BPT_REG_RESET;
			addrLow_r <= `BPT_REG_RESET;
			dataHigh_r <= `BPT_REG_RESET;
			dataLow_r <= `BPT_REG_RESET;
		end
		else if (regWr)
		begin
			case (regAddr)
				`BPT_OFS_CTRL0: ctrl0_r <= regWrData & `BPT_C0_WMASK;
				`BPT_OFS_CTRL1: ctrl1_r <= regWrData & `BPT_C1_WMASK;
				`BPT_OFS_ADDR_HI: addrHigh_r <= regWrData;
				`BPT_OFS_ADDR_LO: addrLow_r <= regWrData;
				`BPT_OFS_DATA_HI: dataHigh_r <= regWrData;
				`BPT_OFS_DATA_LO: dataLow_r <= regWrData;
				default: ;
			endcase
		end
	end

	// Read data valid only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge sys_clk)
	begin
		if (reset || !regRd)
			regRdData_r <= 8'h00;
		else
		begin
			case (regAddr)
				`BPT_OFS_CTRL0: regRdData_r <= ctrl0_r;
				`BPT_OFS_CTRL1: regRdData_r <= ctrl1_r;
				`BPT_OFS_ADDR_HI: regRdData_r <= addrHigh_r;
				`BPT_OFS_ADDR_LO: regRdData_r <= addrLow_r;
				`BPT_OFS_DATA_HI: regRdData_r <= dataHigh_r;
				`BPT_OFS_DATA_LO: regRdData_r <= dataLow_r;
				default: regRdData_r <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Comparators
	// ----------------------------------------
	assign mode = ctrl0_r[`BPT_C0_MODE_MSB:`BPT_C0_MODE_LSB];
	assign dualMode = (mode == `BPT_MODE_SWI_DUAL) || (mode == `BPT_MODE_BDM_DUAL);
	// Direction qualifiers do not apply in the software-interrupt dual mode
	assign dirOk0 = (mode == `BPT_MODE_SWI_DUAL) || !ctrl1_r[`BPT_C1_RWE0]
		|| (cpuBus.rnw == ctrl1_r[`BPT_C1_RW0]);
	assign dirOk1 = (mode != `BPT_MODE_BDM_DUAL) || !ctrl1_r[`BPT_C1_RWE1]
		|| (cpuBus.rnw == ctrl1_r[`BPT_C1_RW1]);
	// Full mode data compare; masks and enable drop bytes
	assign dataOk = !ctrl1_r[`BPT_C1_DBE]
		|| ((ctrl1_r[`BPT_C1_MBH] || (dataHigh_r == cpuBus.data[15:8]))
		&& (ctrl1_r[`BPT_C1_MBL] || (dataLow_r == cpuBus.data[7:0])));
	assign cmp0Hit = cpuBus.valid && !bdmActive && (mode != `BPT_MODE_OFF)
		&& (addrHigh_r == cpuBus.addr[15:8])
		&& (!ctrl0_r[`BPT_C0_ALE0] || (addrLow_r == cpuBus.addr[7:0]))
		&& dirOk0 && (dualMode || dataOk);
	// Second address comparator exists only in dual modes with data enable set
	assign cmp1Hit = cpuBus.valid && !bdmActive && dualMode && ctrl1_r[`BPT_C1_DBE]
		&& (dataHigh_r == cpuBus.addr[15:8])
		&& (!ctrl0_r[`BPT_C0_ALE1] || (dataLow_r == cpuBus.addr[7:0]))
		&& dirOk1;
	assign anyHit = cmp0Hit || cmp1Hit;
	// Executed-only breaks go through the tag queue; the SOFTWARE_INTERRUPT mode always does
	assign tagPath = ctrl0_r[`BPT_C0_PROG_ONLY] || (mode == `BPT_MODE_SWI_DUAL);

	// ----------------------------------------
	// Pin synchronisers and bus clock fall
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : gSync
			always_ff @(posedge sys_clk)
			begin
				if (reset)
				begin
					syncA_r[gi] <= 1'b1;
					syncB_r[gi] <= 1'b1;
				end
				else
				begin
					syncA_r[gi] <= (gi == 0) ? busEClockPin : (gi == 1) ? tagLowPin_n : tagHighPin_n;
					syncB_r[gi] <= syncA_r[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			eclkPrev_r <= 1'b1;
		else
			eclkPrev_r <= syncB_r[0];
	end
	assign eclkFall = eclkPrev_r && !syncB_r[0];

	// ----------------------------------------
	// Tagging state and pin reuse
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			bdmPrev_r <= 1'b0;
		else
			bdmPrev_r <= bdmActive;
	end

	// Debug entry wins over a start command in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (reset || bdmActive)
			tagActive_r <= 1'b0;
		else if (startTaggingCommand)
			tagActive_r <= 1'b1;
	end

	// Serial engine is told to drop commands for as long as tagging runs
	always_ff @(posedge sys_clk)
	begin
		if (reset || bdmActive)
			serialCmdIgnore_r <= 1'b0;
		else if (startTaggingCommand)
			serialCmdIgnore_r <= 1'b1;
	end

	// Shared pins release their drivers while they serve as tag inputs
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			lowStrobePinOut_r <= 1'b1;
			lowStrobePinOe_r <= 1'b0;
			serialPinOut_r <= 1'b1;
			serialPinOe_r <= 1'b0;
		end
		else
		begin
			lowStrobePinOut_r <= cpuLowStrobe_n;
			lowStrobePinOe_r <= cpuLowStrobeEn && !tagActive_r;
			serialPinOut_r <= serialOut;
			serialPinOe_r <= serialOe && !tagActive_r;
		end
	end

	// Latched pin tags wait for the next program fetch; a fetch with no fall clears them
	always_ff @(posedge sys_clk)
	begin
		if (reset || !tagActive_r)
		begin
			pendTagHi_r <= 1'b0;
			pendTagLo_r <= 1'b0;
		end
		else if (eclkFall)
		begin
			pendTagHi_r <= !syncB_r[2];
			pendTagLo_r <= !syncB_r[1];
		end
		else if (cpuBus.valid && cpuBus.progFetch)
		begin
			pendTagHi_r <= 1'b0;
			pendTagLo_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Instruction queue
	// ----------------------------------------
	always_comb
	begin
		pushEntry = '0;
		pushEntry.word = cpuBus.data;
		pushEntry.tag_high_n = pendTagHi_r || (tagPath && anyHit && !cpuBus.addr[0]);
		pushEntry.tag_low_n = pendTagLo_r || (tagPath && anyHit && cpuBus.addr[0]);
		pushEntry.swiKind = (mode == `BPT_MODE_SWI_DUAL) && anyHit && !(pendTagHi_r || pendTagLo_r);
	end

	bpt_tag_queue uQueue (
		.sys_clk(sys_clk),
		.reset(reset),
		.push(cpuBus.valid && cpuBus.progFetch),
		.pushEntry(pushEntry),
		.pop(queueAdvance),
		.headOdd(headOdd),
		.flush(bdmActive),
		.headTagged(headTagged),
		.headSwi(headSwi),
		.full(),
		.empty()
	);

	// ----------------------------------------
	// Break sequencing
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (reset || bdmActive)
			brkState_r <= BRK_IDLE;
		else
		begin
			case (brkState_r)
				BRK_IDLE: if (anyHit && !tagPath)
					brkState_r <= BRK_WAIT;
				BRK_WAIT: if (instrBoundary)
					brkState_r <= BRK_IDLE;
				default: brkState_r <= BRK_IDLE;
			endcase
		end
	end

	// Requests to the CPU: a boundary break lasts one cycle, a head tag holds until the head is popped or flushed; none while debug mode already runs
	always_ff @(posedge sys_clk)
	begin
		if (reset || bdmActive)
		begin
			bdmEntry_r <= 1'b0;
			swiRequest_r <= 1'b0;
		end
		else
		begin
			bdmEntry_r <= ((brkState_r == BRK_WAIT) && instrBoundary)
				|| (headTagged && !headSwi);
			swiRequest_r <= headTagged && headSwi;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence sEclkFallTagged;
		tagActive_r && eclkFall && !syncB_r[2];
	endsequence

	AST_DIR0_QUALIFY : assert property (@(posedge sys_clk) disable iff (reset)
		cmp0Hit && ctrl1_r[`BPT_C1_RWE0] && (mode != `BPT_MODE_SWI_DUAL) |-> cpuBus.rnw == ctrl1_r[`BPT_C1_RW0])
		else $error("comparator zero hit on wrong direction");
	AST_DIR1_QUALIFY : assert property (@(posedge sys_clk) disable iff (reset)
		cmp1Hit && ctrl1_r[`BPT_C1_RWE1] && (mode == `BPT_MODE_BDM_DUAL) |-> cpuBus.rnw == ctrl1_r[`BPT_C1_RW1])
		else $error("comparator one hit on wrong direction");
	AST_ADDR_HIGH : assert property (@(posedge sys_clk) disable iff (reset)
		cmp0Hit |-> cpuBus.addr[15:8] == addrHigh_r)
		else $error("comparator zero hit with upper address mismatch");
	AST_ADDR_LOW : assert property (@(posedge sys_clk) disable iff (reset)
		cmp0Hit && ctrl0_r[`BPT_C0_ALE0] |-> cpuBus.addr[7:0] == addrLow_r)
		else $error("comparator zero hit with lower address mismatch");
	AST_DATA_OFF : assert property (@(posedge sys_clk) disable iff (reset)
		!ctrl1_r[`BPT_C1_DBE] |-> !cmp1Hit)
		else $error("second comparator hit with data compare off");
	AST_FULL_DATA : assert property (@(posedge sys_clk) disable iff (reset)
		cmp0Hit && !dualMode && ctrl1_r[`BPT_C1_DBE] && !ctrl1_r[`BPT_C1_MBH] |-> cpuBus.data[15:8] == dataHigh_r)
		else $error("full mode hit with upper data mismatch");
	AST_NO_HIT_IN_DEBUG : assert property (@(posedge sys_clk) disable iff (reset)
		bdmActive |-> !anyHit ##1 !bdmEntry_r && !swiRequest_r)
		else $error("break raised while debug mode active");
	AST_TAG_STOP : assert property (@(posedge sys_clk) disable iff (reset)
		bdmActive && !bdmPrev_r |=> !tagActive_r && !serialCmdIgnore_r)
		else $error("tagging survived debug entry");
	AST_IGNORE_TRACKS : assert property (@(posedge sys_clk) disable iff (reset)
		tagActive_r == serialCmdIgnore_r)
		else $error("command ignore differs from tagging state");
	AST_TAG_LATCH : assert property (@(posedge sys_clk) disable iff (reset)
		sEclkFallTagged ##1 !bdmActive && tagActive_r |-> pendTagHi_r)
		else $error("high tag not latched at bus clock fall");
	AST_BOUNDARY_BREAK : assert property (@(posedge sys_clk) disable iff (reset)
		(brkState_r == BRK_WAIT) && instrBoundary && !bdmActive ##1 !bdmActive |-> bdmEntry_r)
		else $error("pending break missed the instruction boundary");

endmodule : bpt_breakpoint

`default_nettype wire

/* File: verif/bpt_tag_host.sv */
// Behavioural external tagger that drives the E clock and both tag pins
`timescale 1ns/1ps
`default_nettype none

module bpt_tag_host (
	input wire logic sys_clk,
	input wire logic fire,
	input wire logic wantHi,
	input wire logic wantLo,
	output var logic bus_e_clock,
	output var logic tag_high_n_n,
	output var logic tag_low_n_n
);
	logic [3:0] step_r;

	// Idle: E clock high, tag lines at their pulled-up no-tag level
	initial
	begin
		step_r = 4'h0;
		bus_e_clock = 1'b1;
		tag_high_n_n = 1'b1;
		tag_low_n_n = 1'b1;
	end

	// ----------------------------------------
	// One frame: tags settle, E falls, E rises, tags let go
	// ----------------------------------------
	// Levels are set two cycles before the fall and held past the rise, so the
	// sampling edge never sees them move
	always @(posedge sys_clk)
	begin
		if (fire)
			step_r <= 4'h1;
		else if (step_r == 4'h9)
			step_r <= 4'h0;
		else if (step_r != 4'h0)
			step_r <= step_r + 4'h1;
		if (step_r == 4'h1)
		begin
			tag_high_n_n <= ~wantHi;
			tag_low_n_n <= ~wantLo;
		end
		if (step_r == 4'h3)
			bus_e_clock <= 1'b0;
		if (step_r == 4'h7)
			bus_e_clock <= 1'b1;
		if (step_r == 4'h9)
		begin
			tag_high_n_n <= 1'b1;
			tag_low_n_n <= 1'b1;
		end
	end
endmodule : bpt_tag_host

`default_nettype wire

/* File: verif/breakpoint_compare_and_tagging_tb.sv */
// Self-checking bench for the breakpoint comparators and instruction tagging
`timescale 1ns/1ps
`default_nettype none

module breakpoint_compare_and_tagging_tb;
	import bpt_pkg::*;
	logic sys_clk, reset, regWr, regRd, instrBoundary, queueAdvance, headOdd, bdmActive;
	logic startTaggingCommand, busEClockPin, cpuLowStrobe_n, cpuLowStrobeEn, serialOut, serialOe;
	logic fire, wantHi, wantLo, hostHi_n, hostLo_n;
	logic lowStrobePinOut_r, lowStrobePinOe_r, serialPinOut_r, serialPinOe_r;
	logic tagActive_r, serialCmdIgnore_r, bdmEntry_r, swiRequest_r;
	logic [7:0] regAddr, regWrData, regRdData_r;
	bpt_cpu_bus_t cpuBus;
	int fails, samplesChecked;

	// Shared pins: device level while it drives, tagger level otherwise
	wire logic tagLowPin_n = lowStrobePinOe_r ? lowStrobePinOut_r : hostLo_n;
	wire logic tagHighPin_n = serialPinOe_r ? serialPinOut_r : hostHi_n;

	bpt_breakpoint dut (.sys_clk, .reset, .regAddr, .regWrData, .regWr, .regRd, .regRdData_r, .cpuBus,
		.instrBoundary, .queueAdvance, .headOdd, .bdmActive, .startTaggingCommand, .busEClockPin,
		.tagLowPin_n, .tagHighPin_n, .cpuLowStrobe_n, .cpuLowStrobeEn, .serialOut, .serialOe,
		.lowStrobePinOut_r, .lowStrobePinOe_r, .serialPinOut_r, .serialPinOe_r, .tagActive_r,
		.serialCmdIgnore_r, .bdmEntry_r, .swiRequest_r);

	bpt_tag_host host (.sys_clk(sys_clk), .fire(fire), .wantHi(wantHi), .wantLo(wantLo),
		.bus_e_clock(busEClockPin), .tag_high_n_n(hostHi_n), .tag_low_n_n(hostLo_n));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic completeRun();
		if (fails == 0 && samplesChecked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : completeRun

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 d = regRdData_r;
	endtask : rd

	// One bus cycle, then a boundary; a pending break must show one cycle later
	task automatic brk(input logic [15:0] a, input logic [15:0] d, input logic r, input logic background_debug_mode,
		input logic exp);
		@(posedge sys_clk);
		cpuBus <= '{addr: a, data: d, rnw: r, valid: 1'b1, progFetch: 1'b0};
		bdmActive <= background_debug_mode;
		@(posedge sys_clk);
		cpuBus.valid <= 1'b0;
		bdmActive <= 1'b0;
		@(posedge sys_clk);
		instrBoundary <= 1'b1;
		@(posedge sys_clk);
		instrBoundary <= 1'b0;
		#1 check("bdmEntry", {7'h0, bdmEntry_r}, {7'h0, exp});
		@(posedge sys_clk);
		bdmActive <= 1'b1;
		@(posedge sys_clk);
		bdmActive <= 1'b0;
	endtask : brk

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic regsReset();
		logic [7:0] v;
		for (int i = 0; i < 4; i++)
		begin
			rd(8'h22 + 8'(i), v);
			check("regReset", v, 8'h00);
		end
		check("pinOeIdle", {6'h0, lowStrobePinOe_r, serialPinOe_r}, 8'h03);
		check("pinOutIdle", {6'h0, lowStrobePinOut_r, serialPinOut_r}, 8'h03);
	endtask : regsReset

	// All four written first, so an aliased address shows up
	task automatic regsRw();
		logic [7:0] v;
		for (int i = 0; i < 4; i++)
			wr(8'h22 + 8'(i), 8'h81 >> i);
		wr(8'h30, 8'hff);
		for (int i = 0; i < 4; i++)
		begin
			rd(8'h22 + 8'(i), v);
			check("regRw", v, 8'h81 >> i);
		end
		rd(8'h30, v);
		check("unmapped", v, 8'h00);
	endtask : regsRw

	task automatic addrMatch();
		wr(8'h22, 8'h12);
		wr(8'h23, 8'h34);
		wr(8'h24, 8'hab);
		wr(8'h25, 8'hcd);
		wr(8'h21, 8'h00);
		wr(8'h20, 8'h80);
		brk(16'h1299, 16'h0, 1'b1, 1'b0, 1'b1);
		brk(16'h1399, 16'h0, 1'b1, 1'b0, 1'b0);
		wr(8'h20, 8'h84);
		brk(16'h1299, 16'h0, 1'b1, 1'b0, 1'b0);
		brk(16'h1234, 16'h0, 1'b1, 1'b0, 1'b1);
	endtask : addrMatch

	task automatic dirQual();
		wr(8'h21, 8'h02);
		brk(16'h1234, 16'h0, 1'b1, 1'b0, 1'b0);
		brk(16'h1234, 16'h0, 1'b0, 1'b0, 1'b1);
		wr(8'h21, 8'h03);
		brk(16'h1234, 16'h0, 1'b1, 1'b0, 1'b1);
		brk(16'h1234, 16'h0, 1'b0, 1'b0, 1'b0);
	endtask : dirQual

	task automatic dataMatch();
		wr(8'h21, 8'h40);
		brk(16'h1234, 16'habcd, 1'b1, 1'b0, 1'b1);
		brk(16'h1234, 16'habce, 1'b1, 1'b0, 1'b0);
		brk(16'h1234, 16'hbbcd, 1'b1, 1'b0, 1'b0);
		wr(8'h21, 8'h60);
		brk(16'h1234, 16'h00cd, 1'b1, 1'b0, 1'b1);
		wr(8'h21, 8'h00);
		brk(16'h1234, 16'h0000, 1'b1, 1'b0, 1'b1);
	endtask : dataMatch

	// Second comparator reads the data registers as an address
	task automatic dualMatch();
		wr(8'h20, 8'hc8);
		wr(8'h21, 8'h4c);
		brk(16'habcd, 16'h0, 1'b1, 1'b0, 1'b1);
		brk(16'habcd, 16'h0, 1'b0, 1'b0, 1'b0);
		brk(16'habce, 16'h0, 1'b1, 1'b0, 1'b0);
		brk(16'h1200, 16'h0, 1'b0, 1'b0, 1'b1);
		wr(8'h21, 8'h0c);
		brk(16'habcd, 16'h0, 1'b1, 1'b0, 1'b0);
	endtask : dualMatch

	task automatic bdmBlock();
		wr(8'h20, 8'h84);
		wr(8'h21, 8'h00);
		brk(16'h1234, 16'h0, 1'b1, 1'b1, 1'b0);
		brk(16'h1234, 16'h0, 1'b1, 1'b0, 1'b1);
		wr(8'h20, 8'ha0);
		brk(16'h1299, 16'h0, 1'b1, 1'b0, 1'b0);
	endtask : bdmBlock

	// Software-interrupt dual mode: a hit on a fetched word asks for an interrupt at the head
	task automatic swiRun();
		wr(8'h20, 8'h40);
		wr(8'h21, 8'h00);
		@(posedge sys_clk);
		cpuBus <= '{addr: 16'h1200, data: 16'h0, rnw: 1'b1, valid: 1'b1, progFetch: 1'b1};
		headOdd <= 1'b0;
		@(posedge sys_clk);
		cpuBus <= '0;
		@(posedge sys_clk);
		#1 check("swiRequest", {7'h0, swiRequest_r}, 8'h01);
		check("swiNoDebug", {7'h0, bdmEntry_r}, 8'h00);
		@(posedge sys_clk);
		bdmActive <= 1'b1;
		@(posedge sys_clk);
		bdmActive <= 1'b0;
	endtask : swiRun

	// Start tagging, send one tag frame, fetch one word and watch the head
	task automatic tagRun(input logic hi, input logic lo, input logic odd, input logic exp);
		logic seen;
		seen = 1'b0;
		@(posedge sys_clk);
		startTaggingCommand <= 1'b1;
		headOdd <= odd;
		@(posedge sys_clk);
		startTaggingCommand <= 1'b0;
		#1 check("tagActive", {7'h0, tagActive_r}, 8'h01);
		check("cmdIgnore", {7'h0, serialCmdIgnore_r}, 8'h01);
		@(posedge sys_clk);
		#1 check("pinOe", {6'h0, lowStrobePinOe_r, serialPinOe_r}, 8'h00);
		@(posedge sys_clk);
		fire <= 1'b1;
		wantHi <= hi;
		wantLo <= lo;
		@(posedge sys_clk);
		fire <= 1'b0;
		repeat (14) @(posedge sys_clk);
		cpuBus <= '{addr: 16'h4000, data: 16'h0, rnw: 1'b1, valid: 1'b1, progFetch: 1'b1};
		@(posedge sys_clk);
		cpuBus <= '0;
		repeat (6)
		begin
			@(posedge sys_clk);
			#1 seen = seen | bdmEntry_r;
		end
		check("tagEntry", {7'h0, seen}, {7'h0, exp});
		check("tagHeld", {7'h0, tagActive_r}, 8'h01);
		@(posedge sys_clk);
		bdmActive <= 1'b1;
		@(posedge sys_clk);
		bdmActive <= 1'b0;
		#1 check("tagStop", {7'h0, tagActive_r}, 8'h00);
	endtask : tagRun

	task automatic tagAll();
		wr(8'h20, 8'h00);
		tagRun(1'b1, 1'b0, 1'b0, 1'b1);
		tagRun(1'b1, 1'b0, 1'b1, 1'b0);
		tagRun(1'b0, 1'b1, 1'b1, 1'b1);
		tagRun(1'b1, 1'b1, 1'b0, 1'b1);
		tagRun(1'b0, 1'b0, 1'b0, 1'b0);
	endtask : tagAll

	// ----------------------------------------
	// Clock, main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	initial
	begin
		fails = 0;
		samplesChecked = 0;
		reset = 1'b1;
		{regWr, regRd, instrBoundary, queueAdvance, headOdd, bdmActive} = 6'h0;
		{startTaggingCommand, fire, wantHi, wantLo} = 4'h0;
		{cpuLowStrobe_n, cpuLowStrobeEn, serialOut, serialOe} = 4'hf;
		regAddr = 8'h00;
		regWrData = 8'h00;
		cpuBus = '0;
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		regsReset();
		regsRw();
		addrMatch();
		dirQual();
		dataMatch();
		dualMatch();
		bdmBlock();
		swiRun();
		tagAll();
		completeRun();
	end

	// Whole run needs about 360 cycles
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		completeRun();
	end
endmodule : breakpoint_compare_and_tagging_tb

`default_nettype wire
